/* rtl/ump_top.sv */
`timescale 1ns/1ps
module ump_top
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial pins
    input wire logic [ump_pkg::NCH-1:0] sin,
    input wire logic [ump_pkg::NCH-1:0] irda_in,
    input wire logic [ump_pkg::NCH-1:0] dcd_n,
    output logic [ump_pkg::NCH-1:0] sout,
    output logic [ump_pkg::NCH-1:0] dtr_n,
    output logic [ump_pkg::NCH-1:0] tx_clk_out,
    // UART core side
    input wire logic [ump_pkg::NCH-1:0] core_sout,
    input wire logic [ump_pkg::NCH-1:0] core_irda_out,
    input wire logic [ump_pkg::NCH-1:0] core_tx_empty,
    input wire logic [ump_pkg::NCH-1:0] core_tx_clk_1x,
    input wire logic [ump_pkg::NCH-1:0] core_tx_clk_nx,
    input wire logic [ump_pkg::NCH*8-1:0] core_rx_level,
    output logic [ump_pkg::NCH-1:0] core_rx_data,
    output logic [ump_pkg::NCH-1:0] carrier_present
);
    import ump_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    ump_sync_if sync_bus();

    assign sync_bus.sin_raw = sin;
    assign sync_bus.irda_raw = irda_in;
    assign sync_bus.dcd_raw_n = dcd_n;

    ump_sync ump_sync_i
    (
        .core_clk(core_clk),
        .srst(srst),
        .pins(sync_bus.sink)
    );

    // ************************************************************
    // Register state
    // ************************************************************
    logic [NCH-1:0][7:0] modem_control_reg;
    logic [NCH-1:0][7:0] additional_control_reg;
    logic [NCH-1:0][7:0] clock_select_reg;
    logic [NCH-1:0][7:0] thr;
    logic enh;
    logic [NCH-1:0] dcd_delta;
    logic [NCH-1:0] dcd_prev_n;
    logic [NCH-1:0][7:0] next_modem_control_reg;
    logic [NCH-1:0][7:0] next_additional_control_reg;
    logic [NCH-1:0][7:0] next_clock_select_reg;
    logic [NCH-1:0][7:0] next_thr;
    logic next_enh;
    logic [NCH-1:0] next_dcd_delta;
    logic [NCH-1:0] next_dcd_prev_n;

    // Bus phase state
    logic dp_act;
    logic dp_wr;
    logic [31:0] dp_addr;
    logic rd_wait;
    logic [31:0] rdata;
    logic next_dp_act;
    logic next_dp_wr;
    logic [31:0] next_dp_addr;
    logic next_rd_wait;
    logic [31:0] next_rdata;

    // Pin output state
    logic [NCH-1:0] flow_hold;
    logic [NCH-1:0] dtr_q;
    logic [NCH-1:0] txclk_q;
    logic [NCH-1:0] sout_q;
    logic [NCH-1:0] rx_q;
    logic [NCH-1:0] next_flow_hold;
    logic [NCH-1:0] next_dtr_q;
    logic [NCH-1:0] next_txclk_q;
    logic [NCH-1:0] next_sout_q;
    logic [NCH-1:0] next_rx_q;

    logic [NCH-1:0] ir_on;
    logic [31:0] stat_word;
    logic addr_take;
    logic [1:0] ch;
    logic [3:0] ofs;

    // ************************************************************
    // Bus phases
    // ************************************************************
    assign addr_take = hsel && hready && htrans[1];
    // Reads insert one wait state
    assign hreadyout = !rd_wait;
    assign hresp = 1'b0;
    assign hrdata = rdata;

    always_comb
    begin
        next_dp_act = dp_act;
        next_dp_wr = dp_wr;
        next_dp_addr = dp_addr;
        next_rd_wait = 1'b0;
        next_rdata = rdata;
        if (hready)
        begin
            next_dp_act = addr_take;
            next_dp_wr = hwrite;
            next_dp_addr = haddr;
            next_rd_wait = addr_take && !hwrite;
        end
        if (rd_wait)
        begin
            next_rdata = read_word(dp_addr);
            next_dp_act = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            dp_act <= 1'b0;
            dp_wr <= 1'b0;
            dp_addr <= 32'h0;
            rd_wait <= 1'b0;
            rdata <= 32'h0;
        end
        else
        begin
            dp_act <= next_dp_act;
            dp_wr <= next_dp_wr;
            dp_addr <= next_dp_addr;
            rd_wait <= next_rd_wait;
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb
    begin
        stat_word = 32'h0;
        stat_word[STAT_DCD_LSB +: NCH] = carrier_present;
        stat_word[STAT_DELTA_LSB +: NCH] = dcd_delta;
        stat_word[STAT_DTR_LSB +: NCH] = dtr_q;
    end

    function automatic logic [31:0] read_word(input logic [31:0] a);
        logic [1:0] c;
        logic [3:0] o;
        c = chan_of(a);
        o = a[3:0];
        // Unmapped addresses read zero
        read_word = 32'h0;
        if (chan_hit(a) && o == OFS_MODEM_CTL)
            read_word = {24'h0, modem_control_reg[c]};
        else if (chan_hit(a) && o == OFS_ADD_CTL)
            read_word = {24'h0, additional_control_reg[c]};
        else if (chan_hit(a) && o == OFS_CLK_SEL)
            read_word = {24'h0, clock_select_reg[c]};
        else if (chan_hit(a) && o == OFS_THR)
            read_word = {24'h0, thr[c]};
        else if (a == {24'h0, ADDR_ENH})
            read_word = {31'h0, enh};
        else if (a == {24'h0, ADDR_STAT})
            read_word = stat_word;
    endfunction

    // ************************************************************
    // Register writes and carrier status
    // ************************************************************
    assign ch = chan_of(dp_addr);
    assign ofs = dp_addr[3:0];

    always_comb
    begin
        next_modem_control_reg = modem_control_reg;
        next_additional_control_reg = additional_control_reg;
        next_clock_select_reg = clock_select_reg;
        next_thr = thr;
        next_enh = enh;
        next_dcd_delta = dcd_delta;
        next_dcd_prev_n = sync_bus.dcd_sync_n;
        // Writes land at the end of the data phase
        if (dp_act && dp_wr)
        begin
            if (chan_hit(dp_addr) && ofs == OFS_MODEM_CTL)
                next_modem_control_reg[ch] = hwdata[7:0];
            else if (chan_hit(dp_addr) && ofs == OFS_ADD_CTL)
                next_additional_control_reg[ch] = hwdata[7:0];
            else if (chan_hit(dp_addr) && ofs == OFS_CLK_SEL)
                next_clock_select_reg[ch] = hwdata[7:0];
            else if (chan_hit(dp_addr) && ofs == OFS_THR)
                next_thr[ch] = hwdata[7:0];
            else if (dp_addr == {24'h0, ADDR_ENH})
                next_enh = hwdata[ENH_BIT];
            else if (dp_addr == {24'h0, ADDR_STAT})
                next_dcd_delta = dcd_delta & ~hwdata[STAT_DELTA_LSB +: NCH];
        end
        // Change seen in the clear cycle still sets
        next_dcd_delta = next_dcd_delta |
            (sync_bus.dcd_sync_n ^ dcd_prev_n);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            modem_control_reg <= {NCH{MODEM_CTL_RST}};
            additional_control_reg <= {NCH{ADD_CTL_RST}};
            clock_select_reg <= {NCH{CLK_SEL_RST}};
            thr <= {NCH{THR_RST}};
            enh <= ENH_RST;
            dcd_delta <= '0;
            dcd_prev_n <= '1;
        end
        else
        begin
            modem_control_reg <= next_modem_control_reg;
            additional_control_reg <= next_additional_control_reg;
            clock_select_reg <= next_clock_select_reg;
            thr <= next_thr;
            enh <= next_enh;
            dcd_delta <= next_dcd_delta;
            dcd_prev_n <= next_dcd_prev_n;
        end
    end

    // ************************************************************
    // Per-channel pin logic
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            ir_on[i] = enh && modem_control_reg[i][MODEM_CTL_IR_BIT];
            next_rx_q[i] = ir_on[i] ? sync_bus.irda_sync[i]
                                    : sync_bus.sin_sync[i];
            next_sout_q[i] = ir_on[i] ? core_irda_out[i]
                                      : core_sout[i];
            next_txclk_q[i] = core_tx_clk_1x[i];
            // Flow hold adds a cycle on the auto flow path
            next_flow_hold[i] =
                (core_rx_level[i*8 +: 8] >= thr[i]);
            // Clock output overrides half-duplex and manual
            case (clock_select_reg[i][CLK_SEL_TXO_LSB +: 2])
                TXO_1X: next_dtr_q[i] = core_tx_clk_1x[i];
                TXO_NX: next_dtr_q[i] = core_tx_clk_nx[i];
                default:
                begin
                    case (additional_control_reg[i][ADD_CTL_HD_LSB +: 2])
                        HD_AUTO_FLOW: next_dtr_q[i] = !flow_hold[i];
                        HD_RS485: next_dtr_q[i] = core_tx_empty[i];
                        default: next_dtr_q[i] =
                            !modem_control_reg[i][MODEM_CTL_DTR_BIT];
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flow_hold <= '0;
            dtr_q <= '1;
            txclk_q <= '0;
            sout_q <= '1;
            rx_q <= '1;
        end
        else
        begin
            flow_hold <= next_flow_hold;
            dtr_q <= next_dtr_q;
            txclk_q <= next_txclk_q;
            sout_q <= next_sout_q;
            rx_q <= next_rx_q;
        end
    end

    assign dtr_n = dtr_q;
    assign tx_clk_out = txclk_q;
    assign sout = sout_q;
    assign core_rx_data = rx_q;
    assign carrier_present = ~dcd_prev_n;

endmodule // ump_top

/* rtl/ump_pkg.sv */
package ump_pkg;

    localparam int NCH = 4;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] OFS_MODEM_CTL = 4'h0;
    localparam logic [3:0] OFS_ADD_CTL = 4'h4;
    localparam logic [3:0] OFS_CLK_SEL = 4'h8;
    localparam logic [3:0] OFS_THR = 4'hC;
    localparam logic [7:0] ADDR_ENH = 8'h40;
    localparam logic [7:0] ADDR_STAT = 8'h44;

    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int MODEM_CTL_DTR_BIT = 0;
    localparam int MODEM_CTL_IR_BIT = 6;
    localparam int ADD_CTL_HD_LSB = 3;
    localparam int CLK_SEL_TXO_LSB = 4;
    localparam int ENH_BIT = 0;
    localparam int STAT_DCD_LSB = 0;
    localparam int STAT_DELTA_LSB = 4;
    localparam int STAT_DTR_LSB = 8;

    localparam logic [1:0] HD_MANUAL = 2'h0;
    localparam logic [1:0] HD_AUTO_FLOW = 2'h2;
    localparam logic [1:0] HD_RS485 = 2'h3;
    localparam logic [1:0] TXO_OFF = 2'h0;
    localparam logic [1:0] TXO_1X = 2'h1;
    localparam logic [1:0] TXO_NX = 2'h2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] MODEM_CTL_RST = 8'h00;
    localparam logic [7:0] ADD_CTL_RST = 8'h00;
    localparam logic [7:0] CLK_SEL_RST = 8'h00;
    localparam logic [7:0] THR_RST = 8'h40;
    localparam logic ENH_RST = 1'b0;

    // ************************************************************
    // Address decode helpers
    // ************************************************************
    function automatic logic chan_hit(input logic [31:0] a);
        chan_hit = (a[31:6] == 26'h0);
    endfunction

    function automatic logic [1:0] chan_of(input logic [31:0] a);
        chan_of = a[5:4];
    endfunction

endpackage

/* rtl/ump_sync_if.sv */
`timescale 1ns/1ps
interface ump_sync_if;
    logic [3:0] sin_raw;
    logic [3:0] irda_raw;
    logic [3:0] dcd_raw_n;
    logic [3:0] sin_sync;
    logic [3:0] irda_sync;
    logic [3:0] dcd_sync_n;

    modport src
    (
        output sin_raw,
        output irda_raw,
        output dcd_raw_n,
        input sin_sync,
        input irda_sync,
        input dcd_sync_n
    );

    modport sink
    (
        input sin_raw,
        input irda_raw,
        input dcd_raw_n,
        output sin_sync,
        output irda_sync,
        output dcd_sync_n
    );
endinterface

/* rtl/ump_sync.sv */
`timescale 1ns/1ps
module ump_sync
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Pin levels in, synchronised levels out
    ump_sync_if.sink pins
);
    import ump_pkg::*;

    logic [11:0] stage1;
    logic [11:0] stage2;
    logic [11:0] next_stage1;
    logic [11:0] next_stage2;

    // ************************************************************
    // Two flip-flop synchronisers
    // ************************************************************
    always_comb
    begin
        next_stage1 = {pins.dcd_raw_n, pins.irda_raw, pins.sin_raw};
        next_stage2 = stage1;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stage1 <= 12'hFFF;
            stage2 <= 12'hFFF;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign pins.sin_sync = stage2[3:0];
    assign pins.irda_sync = stage2[7:4];
    assign pins.dcd_sync_n = stage2[11:8];

endmodule // ump_sync

/* test/ump_chk.sv */
`timescale 1ns/1ps
module ump_chk
import ump_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    // Pins and core side
    input wire logic [ump_pkg::NCH-1:0] sin,
    input wire logic [ump_pkg::NCH-1:0] irda_in,
    input wire logic [ump_pkg::NCH-1:0] dcd_n,
    input wire logic [ump_pkg::NCH-1:0] sout,
    input wire logic [ump_pkg::NCH-1:0] dtr_n,
    input wire logic [ump_pkg::NCH-1:0] tx_clk_out,
    input wire logic [ump_pkg::NCH-1:0] core_sout,
    input wire logic [ump_pkg::NCH-1:0] core_irda_out,
    input wire logic [ump_pkg::NCH-1:0] core_tx_empty,
    input wire logic [ump_pkg::NCH-1:0] core_tx_clk_1x,
    input wire logic [ump_pkg::NCH-1:0] core_tx_clk_nx,
    input wire logic [ump_pkg::NCH-1:0] core_rx_data,
    input wire logic [ump_pkg::NCH-1:0] carrier_present
);
// ****
// Shadow of written control fields
// ****
logic wq;
logic [7:0] wa;
logic enh;
logic [3:0] irb;
logic [3:0][1:0] hd;
logic [3:0][1:0] txo;
logic [1:0] run;
logic [3:0] irm;
logic ok;
assign irm = {4{enh}} & irb;
assign ok = (run == 2'd3);
always_ff @(posedge core_clk)
begin
    if (srst)
    begin
        wq <= 1'b0;
        wa <= 8'h00;
        enh <= 1'b0;
        irb <= 4'h0;
        hd <= '0;
        txo <= '0;
        run <= 2'd0;
    end
    else
    begin
        if (run != 2'd3)
            run <= run + 2'd1;
        if (hready)
        begin
            wq <= hsel && htrans[1] && hwrite;
            wa <= haddr[7:0];
        end
        if (wq && hready && wa == ADDR_ENH)
            enh <= hwdata[ENH_BIT];
        if (wq && hready && wa[7:6] == 2'b00)
        begin
            case (wa[3:0])
                OFS_MODEM_CTL: irb[wa[5:4]] <= hwdata[MODEM_CTL_IR_BIT];
                OFS_ADD_CTL: hd[wa[5:4]] <= hwdata[4:3];
                OFS_CLK_SEL: txo[wa[5:4]] <= hwdata[5:4];
                default: ;
            endcase
        end
    end
end
// ****
// Properties
// ****
default clocking cb @(posedge core_clk);
endclocking
default disable iff (srst);
sequence rd_take;
    hsel && hready && htrans[1] && !hwrite;
endsequence
sequence dcd_low3;
    $fell(dcd_n[2]) ##1 !dcd_n[2] [*2];
endsequence
tx_clk_a: assert property (ok |-> tx_clk_out == $past(core_tx_clk_1x))
    else $error("tx clock output wrong");
sout_mux_a: assert property (ok |->
    sout == $past(core_irda_out & irm | core_sout & ~irm))
    else $error("serial output source wrong");
rx_mux_a: assert property (ok |-> core_rx_data ==
    ($past(irda_in, 3) & $past(irm) | $past(sin, 3) & ~$past(irm)))
    else $error("receive source wrong");
carrier_a: assert property (ok |-> carrier_present == ~$past(dcd_n, 3))
    else $error("carrier level wrong");
dcd_sync_a: assert property (dcd_low3 |->
    !carrier_present[2] ##1 carrier_present[2])
    else $error("carrier sync delay wrong");
rd_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
rs485_dir_a: assert property (ok &&
    $past(txo[3] == TXO_OFF && hd[3] == HD_RS485)
    |-> dtr_n[3] == $past(core_tx_empty[3]))
    else $error("half duplex direction wrong");
dtr_clk_a: assert property (ok &&
    $past(txo[1] == TXO_1X || txo[1] == TXO_NX) |-> dtr_n[1] ==
    $past(txo[1] == TXO_1X ? core_tx_clk_1x[1] : core_tx_clk_nx[1]))
    else $error("terminal ready clock wrong");
endmodule // ump_chk

bind ump_top ump_chk ump_chk_i
(
    .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .sin(sin), .irda_in(irda_in), .dcd_n(dcd_n),
    .sout(sout), .dtr_n(dtr_n), .tx_clk_out(tx_clk_out),
    .core_sout(core_sout), .core_irda_out(core_irda_out),
    .core_tx_empty(core_tx_empty), .core_tx_clk_1x(core_tx_clk_1x),
    .core_tx_clk_nx(core_tx_clk_nx), .core_rx_data(core_rx_data),
    .carrier_present(carrier_present)
);

/* test/ump_xcvr.sv */
`timescale 1ns/1ps
module ump_xcvr
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Line from the block
    input wire logic [3:0] sout,
    // Line to the block
    output logic [3:0] sin,
    output logic [3:0] irda_in,
    output logic [3:0] dcd_n,
    // Commands
    input wire logic [3:0] ir_lvl,
    input wire logic [3:0] carrier
);
// ****
// Loopback transceiver
// ****
always_ff @(posedge core_clk)
begin
    sin <= srst ? 4'hF : sout;
    irda_in <= srst ? 4'hF : ir_lvl;
    dcd_n <= srst ? 4'hF : ~carrier;
end
endmodule // ump_xcvr

/* test/uart_modem_pin_functions_tb_top.sv */
`timescale 1ns/1ps
module uart_modem_pin_functions_tb_top;
import ump_pkg::*;
logic core_clk, srst, hsel, hwrite, hreadyout, hresp;
logic [1:0] htrans;
logic [31:0] haddr, hwdata, hrdata, core_rx_level, q;
logic [3:0] sin, irda_in, dcd_n, sout, dtr_n, tx_clk_out, ir_lvl, carrier;
logic [3:0] core_sout, core_irda_out, core_tx_empty, core_rx_data;
logic [3:0] core_tx_clk_1x, core_tx_clk_nx, carrier_present;
int err_total, checked, cyc;
// ****
// Instances
// ****
ump_top ump_top_i (.core_clk(core_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sin(sin), .irda_in(irda_in),
    .dcd_n(dcd_n), .sout(sout), .dtr_n(dtr_n), .tx_clk_out(tx_clk_out),
    .core_sout(core_sout), .core_irda_out(core_irda_out),
    .core_tx_empty(core_tx_empty), .core_tx_clk_1x(core_tx_clk_1x),
    .core_tx_clk_nx(core_tx_clk_nx), .core_rx_level(core_rx_level),
    .core_rx_data(core_rx_data), .carrier_present(carrier_present));
ump_xcvr ump_xcvr_i (.core_clk(core_clk), .srst(srst), .sout(sout),
    .sin(sin), .irda_in(irda_in), .dcd_n(dcd_n), .ir_lvl(ir_lvl),
    .carrier(carrier));
// ****
// Tasks
// ****
task end_sim;
    if (err_total == 0 && checked > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
        err_total = err_total + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
endtask
task rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("response", {31'h0, hresp}, 32'h0);
    chk(nm, q, exp);
endtask
// ****
// Clock, free core clocks, timeout
// ****
initial
begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
end
always @(posedge core_clk)
begin
    core_tx_clk_1x <= ~core_tx_clk_1x;
    core_tx_clk_nx <= ~core_tx_clk_nx;
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
        err_total = err_total + 1;
        end_sim();
    end
end
// ****
// Tests
// ****
initial
begin
    srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; core_sout = 4'hF; core_irda_out = 4'h0;
    core_tx_empty = 4'h0; core_tx_clk_1x = 4'h0; core_tx_clk_nx = 4'hF;
    core_rx_level = 32'h0; ir_lvl = 4'h0; carrier = 4'h0;
    err_total = 0; checked = 0; cyc = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rchk("threshold", 32'h0C, {24'h0, THR_RST});
    rchk("status", ADDR_STAT, 32'hF00);
    bus(1'b1, 32'h80, 32'hFF);
    rchk("unmapped", 32'h80, 32'h0);
    bus(1'b1, 32'h10, 32'h40);
    repeat (8) @(posedge core_clk);
    chk("rx plain", core_rx_data, 4'hF);
    ir_lvl <= 4'h2;
    bus(1'b1, ADDR_ENH, 32'h1);
    repeat (8) @(posedge core_clk);
    chk("sout ir", sout, 4'hD);
    chk("rx ir", core_rx_data, 4'hF);
    carrier <= 4'h4;
    repeat (8) @(posedge core_clk);
    chk("carrier", carrier_present, 4'h4);
    rchk("status dcd", ADDR_STAT, 32'hF44);
    bus(1'b1, ADDR_STAT, 32'hF0);
    rchk("status clr", ADDR_STAT, 32'hF04);
    @(negedge core_clk);
    chk("tx clk", tx_clk_out, {~core_tx_clk_1x});
    bus(1'b1, 32'h18, {26'h0, TXO_1X, 4'h0});
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("dtr 1x", dtr_n[1], {~core_tx_clk_1x[1]});
    bus(1'b1, 32'h18, {26'h0, TXO_NX, 4'h0});
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("dtr nx", dtr_n[1], {~core_tx_clk_nx[1]});
    bus(1'b1, 32'h10, 32'h41);
    bus(1'b1, 32'h18, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("dtr manual", dtr_n[1], 1'b0);
    bus(1'b1, 32'h0C, 32'h20);
    bus(1'b1, 32'h04, {27'h0, HD_AUTO_FLOW, 3'h0});
    for (int i = 0; i < 4; i++)
    begin
        core_rx_level[7:0] <= (i == 3) ? 8'h1F : 8'h1F + 8'(i);
        repeat (4) @(posedge core_clk);
        chk("flow", dtr_n[0], (i == 0 || i == 3));
    end
    bus(1'b1, 32'h34, {27'h0, HD_RS485, 3'h0});
    for (int t = 0; t < 2; t++)
    begin
        core_tx_empty <= {t[0], 3'h0};
        repeat (3) @(posedge core_clk);
        chk("rs485", dtr_n[3], t[0]);
    end
    end_sim();
end
endmodule // uart_modem_pin_functions_tb_top
